//--- rtl/program_load_control.sv
// Purpose: serial-host load and read-back of program and parity memory
// Assumes: link side hands over decoded command bytes on its own clock
// Notes: one request in flight per link; writes are posted into the queue
`timescale 1ns/100ps
module req_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("req_fifo depth must be a power of two");
	end
	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	full_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!in_ready && !pop |=> !in_ready && $stable(wr_r))
		else $error("fifo took data while full");
endmodule : req_fifo

module program_load_control import load_ctrl_pkg::*; #(
	parameter int ADDR_W = 10,
	parameter int CHECK_CYC = CHECK_CYCLES,
	parameter logic [7:0] FW_REV = 8'h01 // Arbitrary value
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic link_rst_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [7:0] req_code,
	input wire logic [7:0] req_wdata,
	input wire logic req_stop,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic data_run_open,
	input wire logic cpu_fetch_req,
	input wire logic [ADDR_W-1:0] cpu_fetch_addr,
	output logic cpu_hold,
	output logic fetch_from_ram,
	output logic cpu_fetch_valid,
	output logic [7:0] cpu_fetch_data,
	output logic parity_error
);
	localparam int DEPTH = 1 << ADDR_W;
	if (ADDR_W < 4 || ADDR_W > 16 || DEPTH > CHECK_CYC || FW_REV == REV_INVALID || FW_REV == REV_RESET)
	begin : g_chk
		$error("program_load_control parameters out of range");
	end

	function automatic logic [ADDR_W-1:0] idx(input logic [15:0] p);
		return p[ADDR_W-1:0];
	endfunction : idx

	// Link domain
	link_req_t hold_r;
	logic req_tgl_r;
	logic busy_r;
	logic ack_s1_r, ack_s2_r, ack_s3_r;
	logic ack_tgl_r;
	logic [7:0] rsp_data_r;
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_s3_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_tgl_r;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
		end
	end
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			hold_r <= '0;
			req_tgl_r <= 1'b0;
			busy_r <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			if (req_valid && req_ready) begin
				hold_r <= '{write: req_write, code: req_code, data: req_wdata};
				req_tgl_r <= ~req_tgl_r;
				busy_r <= 1'b1;
				req_ready <= 1'b0;
			end else if (busy_r && (ack_s2_r ^ ack_s3_r)) begin
				busy_r <= 1'b0;
				req_ready <= 1'b1;
				rsp_valid <= !hold_r.write;
				// Core data is held stable across the ack toggle
				rsp_data <= hold_r.write ? 8'h00 : rsp_data_r;
			end else begin
				req_ready <= !busy_r;
			end
		end
	end
	always_ff @(posedge link_clk) begin
		if (!link_rst_n) begin
			data_run_open <= 1'b0;
		end else if (req_valid && req_ready && req_code == CMD_DATA) begin
			data_run_open <= 1'b1;
		end else if (req_stop) begin
			data_run_open <= 1'b0;
		end
	end

	// Core domain: request crossing
	logic rq_s1_r, rq_s2_r, rq_s3_r;
	logic pend_r;
	link_req_t pend_data_r;
	logic f_in_ready, f_out_valid, f_out_ready;
	link_req_t f_out;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rq_s1_r <= 1'b0;
			rq_s2_r <= 1'b0;
			rq_s3_r <= 1'b0;
		end else begin
			rq_s1_r <= req_tgl_r;
			rq_s2_r <= rq_s1_r;
			rq_s3_r <= rq_s2_r;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
			pend_data_r <= '0;
		end else if (rq_s2_r ^ rq_s3_r) begin
			pend_r <= 1'b1;
			pend_data_r <= hold_r;
		end else if (f_in_ready) begin
			pend_r <= 1'b0;
		end
	end
	req_fifo #(.WIDTH($bits(link_req_t)), .DEPTH(16)) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(pend_r),
		.in_ready(f_in_ready),
		.in_data(pend_data_r),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out)
	);

	// Registers and memories
	logic [7:0] ctrl_r;
	logic [15:0] start_r;
	logic [15:0] ptr_r;
	logic [7:0] rev_r;
	logic [7:0] prog_r [DEPTH];
	logic [7:0] par_r [DEPTH];
	check_state_t chk_r;
	logic [ADDR_W:0] sweep_r;
	logic bad_r;
	logic loaded_r;
	logic exec_op;
	logic data_op;
	logic mem_wr;
	logic start_chk;
	// Processor fetch owns the memory port; check sweep also stalls the queue
	assign f_out_ready = !cpu_fetch_req && chk_r == CHK_IDLE;
	assign exec_op = f_out_valid && f_out_ready;
	assign data_op = exec_op && f_out.code == CMD_DATA && ctrl_r[BIT_ACCESS]
		&& (f_out.write == !ctrl_r[BIT_DIR]);
	assign mem_wr = data_op && f_out.write;
	assign start_chk = exec_op && f_out.write && f_out.code == CMD_CONTROL
		&& f_out.data[BIT_EXEC] && !ctrl_r[BIT_EXEC] && !f_out.data[BIT_HOLD];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_r <= CONTROL_RESET;
		end else if (exec_op && f_out.write && f_out.code == CMD_CONTROL) begin
			ctrl_r <= f_out.data;
		end else if (chk_r == CHK_DONE && (bad_r || !loaded_r)) begin
			ctrl_r[BIT_EXEC] <= 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			start_r <= START_RESET;
		end else if (exec_op && f_out.write && f_out.code == CMD_START_LO) begin
			start_r[7:0] <= f_out.data;
		end else if (exec_op && f_out.write && f_out.code == CMD_START_HI) begin
			start_r[15:8] <= f_out.data;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ptr_r <= START_RESET;
		end else if (ctrl_r[BIT_CLEAR]) begin
			ptr_r <= start_r;
		end else if (data_op) begin
			ptr_r <= ptr_r + 16'h0001;
		end
	end
	always_ff @(posedge clock) begin
		if (mem_wr && ctrl_r[BIT_PARITY_ACCESS_SELECT]) begin
			par_r[idx(ptr_r)] <= f_out.data;
		end
		if (mem_wr && !ctrl_r[BIT_PARITY_ACCESS_SELECT]) begin
			prog_r[idx(ptr_r)] <= f_out.data;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			loaded_r <= 1'b0;
		end else if (mem_wr && !ctrl_r[BIT_PARITY_ACCESS_SELECT]) begin
			loaded_r <= 1'b1;
		end
	end

	// Answers and acks back to the link
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_tgl_r <= 1'b0;
			rsp_data_r <= 8'h00;
		end else if (pend_r && f_in_ready && pend_data_r.write) begin
			ack_tgl_r <= ~ack_tgl_r;
		end else if (exec_op && !f_out.write) begin
			ack_tgl_r <= ~ack_tgl_r;
			case (f_out.code)
				CMD_CONTROL: rsp_data_r <= ctrl_r;
				CMD_START_LO: rsp_data_r <= start_r[7:0];
				CMD_START_HI: rsp_data_r <= start_r[15:8];
				CMD_REVISION: rsp_data_r <= rev_r;
				CMD_DATA: begin
					if (data_op) begin
						rsp_data_r <= ctrl_r[BIT_PARITY_ACCESS_SELECT] ? par_r[idx(ptr_r)] : prog_r[idx(ptr_r)];
					end else begin
						rsp_data_r <= 8'h00;
					end
				end
				default: rsp_data_r <= 8'h00;
			endcase
		end
	end

	// Load check sweep: one location per cycle, bounded by the check time
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			chk_r <= CHK_IDLE;
			sweep_r <= '0;
			bad_r <= 1'b0;
			rev_r <= REV_RESET;
		end else begin
			case (chk_r)
				CHK_IDLE: begin
					if (start_chk) begin
						chk_r <= CHK_SWEEP;
						sweep_r <= '0;
						bad_r <= 1'b0;
					end
				end
				CHK_SWEEP: begin
					if ((^prog_r[sweep_r[ADDR_W-1:0]]) != par_r[sweep_r[ADDR_W-1:0]][0]) begin
						bad_r <= 1'b1;
					end
					sweep_r <= sweep_r + 1'b1;
					if (sweep_r == (ADDR_W+1)'(DEPTH - 1)) begin
						chk_r <= CHK_DONE;
					end
				end
				CHK_DONE: begin
					rev_r <= (bad_r || !loaded_r) ? REV_INVALID : FW_REV;
					chk_r <= CHK_IDLE;
				end
				default: chk_r <= CHK_IDLE;
			endcase
		end
	end

	// Sweep length counted here; a long delay range is too heavy to unroll
	logic [31:0] chk_span_r;
	always_ff @(posedge clock) begin
		if (!rst_n || chk_r != CHK_SWEEP) begin
			chk_span_r <= '0;
		end else begin
			chk_span_r <= chk_span_r + 32'h00000001;
		end
	end

	// Processor side; hold drives the processor reset and also blocks fetch valid and parity error
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cpu_hold <= 1'b0;
			fetch_from_ram <= 1'b0;
			cpu_fetch_valid <= 1'b0;
			cpu_fetch_data <= 8'h00;
			parity_error <= 1'b0;
		end else begin
			cpu_hold <= ctrl_r[BIT_HOLD];
			fetch_from_ram <= ctrl_r[BIT_EXEC];
			cpu_fetch_valid <= cpu_fetch_req && ctrl_r[BIT_EXEC] && !ctrl_r[BIT_HOLD];
			cpu_fetch_data <= prog_r[cpu_fetch_addr];
			parity_error <= cpu_fetch_req && ctrl_r[BIT_EXEC] && !ctrl_r[BIT_HOLD] && ctrl_r[BIT_PARITY_CHECK_ENABLE]
				&& ((^prog_r[cpu_fetch_addr]) != par_r[cpu_fetch_addr][0]);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	ctrl_reset_a: assert property (@(posedge clock) disable iff (1'b0) !rst_n |=> ctrl_r == CONTROL_RESET)
		else $error("control not zero after reset");
	access_block_a: assert property (exec_op && f_out.code == CMD_DATA && !ctrl_r[BIT_ACCESS]
		&& !ctrl_r[BIT_CLEAR] |=> $stable(ptr_r))
		else $error("pointer moved while access blocked");
	hold_follow_a: assert property (exec_op && f_out.write && f_out.code == CMD_CONTROL
		|=> ##1 cpu_hold == $past(f_out.data[BIT_HOLD], 2))
		else $error("processor hold not following control");
	hold_isolate_a: assert property (exec_op && f_out.write && f_out.code == CMD_CONTROL
		|=> $stable(start_r) && $stable(rev_r))
		else $error("hold changed visible registers");
	parity_gate_a: assert property (parity_error |-> $past(ctrl_r[BIT_PARITY_CHECK_ENABLE]))
		else $error("parity error while checking off");
	exec_fetch_a: assert property (cpu_fetch_valid |-> $past(ctrl_r[BIT_EXEC]) && !$past(ctrl_r[BIT_HOLD]))
		else $error("fetch served without execute flag");
	ptr_clear_a: assert property (ctrl_r[BIT_CLEAR] |=> ptr_r == $past(start_r))
		else $error("pointer not held at start");
	ptr_step_a: assert property (data_op && !ctrl_r[BIT_CLEAR] |=> ptr_r == $past(ptr_r) + 16'h0001)
		else $error("pointer did not advance by one");
	check_start_a: assert property (start_chk |=> chk_r == CHK_SWEEP)
		else $error("load check did not start");
	check_time_a: assert property (chk_r == CHK_SWEEP |-> chk_span_r < 32'(CHECK_CYC))
		else $error("load check did not finish");
	check_fail_a: assert property (chk_r == CHK_DONE && (bad_r || !loaded_r) |=> rev_r == REV_INVALID
		&& !ctrl_r[BIT_EXEC])
		else $error("invalid load not reported");
	par_route_a: assert property (mem_wr && ctrl_r[BIT_PARITY_ACCESS_SELECT] |=> par_r[idx($past(ptr_r))] == $past(f_out.data))
		else $error("parity write misrouted");
	run_stop_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		req_stop && !(req_valid && req_ready && req_code == CMD_DATA) |=> !data_run_open)
		else $error("run stayed open after stop");
	load_write_c: cover property (mem_wr ##[1:50] mem_wr);
	read_back_c: cover property (data_op && !f_out.write);
	queue_full_c: cover property (!f_in_ready && pend_r);
	check_pass_c: cover property (chk_r == CHK_DONE && loaded_r && !bad_r);
endmodule : program_load_control

//--- rtl/load_ctrl_pkg.sv
// Purpose: constants and carriers for the program memory load controller
// Assumes: byte-wide command codes from the serial host side
// Notes: Functional notes below
// Functional notes
// - Memory access only while access select set
// - Processor held in reset while hold set
// - Processor hold touches no visible register
// - Parity checked on fetch while enable set
// - Fetch from memory only while execute set
// - Parity select routes data port to parity
// - Direction bit chooses write or read
// - Byte run continues until host stop
// - Pointer held at start location while clear set
// - Control register at 60h, resets zero
// - Transfers start at the start location
// - Load check reports revision or FFh
package load_ctrl_pkg;
	localparam logic [7:0] CMD_REVISION = 8'h41;
	localparam logic [7:0] CMD_CONTROL = 8'h60;
	localparam logic [7:0] CMD_DATA = 8'h61;
	localparam logic [7:0] CMD_START_LO = 8'h62;
	localparam logic [7:0] CMD_START_HI = 8'h63;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] REV_INVALID = 8'hff;
	localparam logic [7:0] REV_RESET = 8'h00;
	localparam logic [15:0] START_RESET = 16'h0000;
	localparam int BIT_ACCESS = 7;
	localparam int BIT_HOLD = 6;
	localparam int BIT_PARITY_CHECK_ENABLE = 4;
	localparam int BIT_EXEC = 3;
	localparam int BIT_PARITY_ACCESS_SELECT = 2;
	localparam int BIT_DIR = 1;
	localparam int BIT_CLEAR = 0;
	localparam int CHECK_TIME_US = 1000;
	localparam int CLOCK_MHZ = 25;
	localparam int CHECK_CYCLES = CHECK_TIME_US * CLOCK_MHZ;
	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [7:0] data;
	} link_req_t;
	typedef enum logic [1:0] {
		CHK_IDLE = 2'b00,
		CHK_SWEEP = 2'b01,
		CHK_DONE = 2'b11
	} check_state_t;
endpackage : load_ctrl_pkg

//--- verif/link_host_model.sv
// Purpose: host side of the command link, one request at a time
// Assumes: requests are taken on a link edge with valid and ready high
// Notes: released code and data lines show the inverse; the write line keeps its value
`timescale 1ns/100ps
module link_host_model (
	input wire logic link_clk,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	output logic req_valid,
	output logic req_write,
	output logic [7:0] req_code,
	output logic [7:0] req_wdata,
	output logic req_stop
);
	int fails = 0;
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_code = 8'h00;
		req_wdata = 8'h00;
		req_stop = 1'b0;
	end
	// Requests stand for the lower device address only
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		q = 8'hxx;
		@(posedge link_clk);
		while (req_ready !== 1'b1 && n < 3000) begin
			@(posedge link_clk);
			n++;
		end
		if (n >= 3000)
			fails++;
		req_valid <= 1'b1;
		req_write <= w;
		req_code <= c;
		req_wdata <= d;
		@(posedge link_clk);
		req_valid <= 1'b0;
		req_code <= ~c;
		req_wdata <= ~d;
		n = 0;
		while (!w && n < 3000) begin
			@(posedge link_clk);
			n++;
			if (rsp_valid === 1'b1) begin
				q = rsp_data;
				n = 5000;
			end
		end
		if (!w && n == 3000)
			fails++;
	endtask : xfer
	// Closes a byte run
	task automatic stop();
		@(posedge link_clk);
		req_stop <= 1'b1;
		@(posedge link_clk);
		req_stop <= 1'b0;
	endtask : stop
endmodule : link_host_model

//--- verif/test_program_load_control.sv
// Purpose: self-checking bench for the program memory load controller
// Assumes: small memory index so the load check sweep stays short
// Notes: expected memory image is kept in the bench
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_program_load_control import load_ctrl_pkg::*;;
	localparam int AW = 4;
	localparam logic [7:0] REV = 8'h5a; // Arbitrary value
	logic clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0, cpu_fetch_req = 1'b0;
	logic [AW-1:0] cpu_fetch_addr = '0;
	logic req_valid, req_write, req_stop, req_ready, rsp_valid, data_run_open;
	logic cpu_hold, fetch_from_ram, cpu_fetch_valid, parity_error;
	logic [7:0] req_code, req_wdata, rsp_data, cpu_fetch_data, q, v, st;
	logic [7:0] mem [16];
	logic [3:0] k;
	logic [7:0] codes [5] = '{CMD_CONTROL, CMD_START_LO, CMD_START_HI, CMD_REVISION, 8'h70};
	int num_errors = 0, total_checks = 0, seed = 13352;
	initial forever #20 clock = ~clock;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	program_load_control #(.ADDR_W(AW), .FW_REV(REV)) i_program_load_control (.clock(clock), .rst_n(rst_n),
		.link_clk(link_clk), .link_rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_code(req_code), .req_wdata(req_wdata), .req_stop(req_stop), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .data_run_open(data_run_open),
		.cpu_fetch_req(cpu_fetch_req), .cpu_fetch_addr(cpu_fetch_addr), .cpu_hold(cpu_hold),
		.fetch_from_ram(fetch_from_ram), .cpu_fetch_valid(cpu_fetch_valid),
		.cpu_fetch_data(cpu_fetch_data), .parity_error(parity_error));
	link_host_model i_link_host_model (.link_clk(link_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
		.req_wdata(req_wdata), .req_stop(req_stop));
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		i_link_host_model.xfer(1'b1, c, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] c);
		i_link_host_model.xfer(1'b0, c, 8'h00, q);
	endtask : rd
	// Pointer clear pulsed around the chosen set-up
	task automatic setup(input logic [7:0] b);
		wr(CMD_CONTROL, b);
		wr(CMD_CONTROL, b | 8'h01);
		wr(CMD_CONTROL, b);
	endtask : setup
	task automatic fetch(input logic [3:0] a, input logic pe);
		@(posedge clock);
		cpu_fetch_req <= 1'b1;
		cpu_fetch_addr <= a;
		@(posedge clock);
		cpu_fetch_req <= 1'b0;
		#1;
		`CHK("fetch valid", 1'b1, cpu_fetch_valid)
		`CHK("fetch data", mem[a], cpu_fetch_data)
		`CHK("parity error", pe, parity_error)
	endtask : fetch
	function automatic logic [7:0] image(input logic [3:0] a, input logic p);
		return p ? {7'h00, ^mem[a]} : mem[a];
	endfunction : image
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	initial begin
		#3000000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		foreach (mem[i])
			mem[i] = 8'($random(seed));
		foreach (codes[j]) begin
			rd(codes[j]);
			`CHK("reset value", 8'h00, q)
		end
		repeat (4) begin
			v = 8'($random(seed)) & 8'hf7;
			wr(CMD_CONTROL, v);
			rd(CMD_CONTROL);
			`CHK("control", v, q)
			`CHK("cpu hold", v[6], cpu_hold)
		end
		$display("register test done");
		// Power-up settle gap, scaled down to keep runs short
		repeat (20) @(posedge clock);
		st = 8'($random(seed)) & 8'h0f;
		wr(CMD_START_LO, st);
		wr(CMD_START_HI, 8'h00);
		wr(CMD_CONTROL, 8'h40);
		wr(CMD_CONTROL, 8'h00);
		rd(CMD_START_LO);
		`CHK("start kept", st, q)
		for (int p = 0; p < 2; p++) begin
			setup(p ? 8'hc4 : 8'hc0);
			for (int i = 0; i < 16; i++)
				wr(CMD_DATA, image(4'(st + i), p[0]));
			`CHK("run open", 1'b1, data_run_open)
			i_link_host_model.stop();
			@(posedge link_clk);
			`CHK("run closed", 1'b0, data_run_open)
		end
		for (int p = 0; p < 2; p++) begin
			setup(p ? 8'hc6 : 8'hc2);
			for (int i = 0; i < 16; i++) begin
				rd(CMD_DATA);
				`CHK("memory byte", image(4'(st + i), p[0]), q)
			end
			`CHK("run open", 1'b1, data_run_open)
			i_link_host_model.stop();
			@(posedge link_clk);
			`CHK("run closed", 1'b0, data_run_open)
		end
		wr(CMD_CONTROL, 8'h42);
		rd(CMD_DATA);
		`CHK("blocked read", 8'h00, q)
		$display("load test done");
		wr(CMD_CONTROL, 8'h18);
		rd(CMD_REVISION);
		`CHK("revision", REV, q)
		`CHK("fetch from ram", 1'b1, fetch_from_ram)
		repeat (4) begin
			k = 4'($random(seed));
			fetch(k, 1'b0);
		end
		setup(8'hc4);
		wr(CMD_DATA, {7'h00, ~^mem[st[3:0]]});
		i_link_host_model.stop();
		wr(CMD_CONTROL, 8'h18);
		rd(CMD_REVISION);
		`CHK("bad revision", REV_INVALID, q)
		rd(CMD_CONTROL);
		`CHK("execute cleared", 8'h10, q)
		`CHK("fetch from ram", 1'b0, fetch_from_ram)
		// Execute set under hold skips the check, so the bad parity byte stays live
		wr(CMD_CONTROL, 8'h58);
		wr(CMD_CONTROL, 8'h18);
		rd(CMD_CONTROL);
		`CHK("control", 8'h18, q)
		fetch(st[3:0], 1'b1);
		wr(CMD_CONTROL, 8'h08);
		rd(CMD_CONTROL);
		`CHK("control", 8'h08, q)
		fetch(st[3:0], 1'b0);
		$display("run test done");
		// Fetches stall the queue drain, so posted writes pile up
		@(posedge clock);
		cpu_fetch_req <= 1'b1;
		for (int i = 0; i < 17; i++)
			wr(CMD_START_LO, 8'(i));
		repeat (40) @(posedge link_clk);
		`CHK("queue full", 1'b0, req_ready)
		@(posedge clock);
		cpu_fetch_req <= 1'b0;
		rd(CMD_START_LO);
		`CHK("queue order", 8'h10, q)
		`CHK("host stalls", 0, i_link_host_model.fails)
		$display("queue test done");
		final_report();
	end
endmodule : test_program_load_control
